// ===== shared/ctp_pkg.sv
// Constants and types of the configurable timer with prescaler.
// Assumes a 32-bit AXI4-Lite register port whose byte address is four times a register index.
package ctp_pkg;

	// ========================================================================
	// Register indices (byte address is four times the index).
	// ========================================================================
	localparam logic [11:0] IDX_COUNT_LOW  = 12'hFD2; // Low count byte.
	localparam logic [11:0] IDX_COUNT_HIGH = 12'hFD3; // High byte or 8-bit period.
	localparam logic [11:0] IDX_CTRL_A     = 12'hFD4; // Run, output, width, postscale.
	localparam logic [11:0] IDX_CTRL_B     = 12'hFD5; // Source, async, prescale.
	localparam logic [11:0] IDX_STATUS     = 12'hFD6; // Sticky event flag, write one to clear.

	// ========================================================================
	// Field positions and reset values.
	// ========================================================================
	localparam int          STATUS_FLAG_BIT = 0;     // Event flag position in the status word.
	localparam logic [7:0]  CTRL_A_RESET    = 8'h00; // Control A after reset.
	localparam logic [7:0]  CTRL_B_RESET    = 8'h00; // Control B after reset.
	localparam logic [7:0]  COUNT_RESET     = 8'h00; // Count bytes after reset.
	localparam logic [1:0]  INSTR_DIV_LAST  = 2'h3;  // Instruction clock is one in four cycles.
	localparam logic [15:0] COUNT_MAX       = 16'hFFFF; // Last value before the 16-bit wrap.

	// ========================================================================
	// Clock source codes.
	// ========================================================================
	localparam logic [2:0] SRC_PIN      = 3'h0; // Routed pin, non-inverted.
	localparam logic [2:0] SRC_PIN_INV  = 3'h1; // Routed pin, inverted.
	localparam logic [2:0] SRC_INSTR    = 3'h2; // Instruction clock.
	localparam logic [2:0] SRC_HF_OSC   = 3'h3; // High-frequency oscillator.
	localparam logic [2:0] SRC_LF_OSC   = 3'h4; // Low-frequency oscillator.
	localparam logic [2:0] SRC_SEC_OSC  = 3'h5; // Secondary oscillator.

	// ========================================================================
	// Bus response codes.
	// ========================================================================
	localparam logic [1:0] RESP_OKAY   = 2'h0; // Access done.
	localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address.

	// Control register A layout.
	typedef struct packed {
		logic       timer_run_enable;     // Counts only while set.
		logic       reserved;             // Reads as zero.
		logic       timer_output;         // Read-only output level.
		logic       counter_width_select; // One selects 16-bit counting.
		logic [3:0] postscale_select;     // Output divide by value plus one.
	} ctp_ctrl_a_t;

	// Control register B layout.
	typedef struct packed {
		logic [2:0] clock_source_select;   // Source code, see above.
		logic       async_input_enable;    // One counts without waiting for an instruction slot.
		logic [3:0] prescale_ratio_select; // Divide by two to the power of the value.
	} ctp_ctrl_b_t;

endpackage : ctp_pkg

// ===== verilog/ctp_timer.sv
// Configurable timer with prescaler, with an AXI4-Lite register slave.
// Assumes the clock pins are asynchronous to clk_sys and slower than half its rate.
//
// Summary of operation
// - Counter runs in 8-bit or 16-bit width.
// - Each prescaled source rising edge adds one.
// - 8-bit mode compares low byte with shadow period.
// - On match clear low byte, reload shadow.
// - 16-bit low byte read latches upper byte coherently.
// - High write buffers; 16-bit low write loads both.
// - 16-bit mode wraps freely past maximum.
// - Source field picks pin, instruction clock, oscillators.
// - Synchronous mode limited to instruction clock rate.
// - Synchronous mode halts during sleep.
// - Asynchronous mode counts each prescaled edge directly.
// - Asynchronous mode keeps counting pin and oscillator edges through sleep.
// - Sixteen prescale ratios from 1:1 to 1:32768.
// - Prescaler count is hidden and unwritable.
// - Prescaler clears on low or control writes.
// - Match or overflow raises an event.
// - Width bit one is 16-bit, zero 8-bit.
// - Counting only while run enable is set.
// - Output toggles per postscaled match or rollover.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps

module ctp_timer (
	// Clock, reset and clock enable.
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        clk_en,
	// Clock sources from outside the domain.
	input  wire logic        ext_clock_pin,
	input  wire logic        high_freq_internal_osc,
	input  wire logic        low_freq_internal_osc,
	input  wire logic        secondary_oscillator,
	// Device sleep state from the power controller.
	input  wire logic        sleep_mode,
	// AXI4-Lite write address channel.
	input  wire logic [15:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data channel.
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response channel.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address channel.
	input  wire logic [15:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data channel.
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Timer results.
	output logic             timer_output,
	output logic             timer_event
);

	// ========================================================================
	// Declarations.
	// ========================================================================
	ctp_pkg::ctp_ctrl_a_t ctrl_a_q;       // Control register A.
	ctp_pkg::ctp_ctrl_b_t ctrl_b_q;       // Control register B.
	logic [15:0]          count_q;        // Live counter.
	logic [7:0]           count_high_q;   // High register: period or high byte buffer.
	logic [7:0]           period_shadow_q; // Shadow period used by the 8-bit compare.
	logic [14:0]          prescale_q;     // Hidden prescaler count.
	logic [3:0]           postscale_q;    // Hidden postscaler count.
	logic                 flag_q;         // Sticky event flag.
	logic                 pending_q;      // Synchronous-mode edge waiting for its slot.
	logic [1:0]           instr_div_q;    // Instruction clock divider.
	logic [3:0]           sync1_q;        // First synchroniser stage.
	logic [3:0]           sync2_q;        // Second synchroniser stage.
	logic [3:0]           prev_q;         // Previous settled level for edge finding.
	logic [3:0]           rise;           // Rising edges of the settled inputs.
	logic [3:0]           fall;           // Falling edges of the settled inputs.
	logic                 instr_tick;     // One cycle in four.
	logic                 src_edge;       // Edge of the selected source.
	logic [14:0]          prescale_mask;  // Low bits that must be all ones to pass.
	logic                 prescale_tick;  // Prescaler output edge.
	logic                 advance;        // Counter moves this cycle.
	logic                 wrap_event;     // Match or overflow this cycle.
	logic [3:0]           src_raw;        // Outside clocks in synchroniser order.
	// Bus state: held channels, decoded write strobes and the read strobe.
	logic                 aw_have_q, w_have_q, w_lane0_q, wr_go, rd_go, psc_clear;
	logic                 wr_low, wr_high, wr_ctrl, wr_stat;
	logic [11:0]          aw_idx_q, ar_idx; // Held write index and live read index.
	logic [7:0]           w_byte_q;         // Held write data byte.

	// ========================================================================
	// Clock input synchroniser.
	// ========================================================================
	// Every outside clock settles through two flops; only the second stage is read.
	assign src_raw = {secondary_oscillator, low_freq_internal_osc, high_freq_internal_osc,
		ext_clock_pin};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			// Two stages and the edge memory, one set per input.
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					{sync1_q[gi], sync2_q[gi], prev_q[gi]} <= 3'b000;
				end else if (clk_en) begin
					sync1_q[gi] <= src_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
					prev_q[gi]  <= sync2_q[gi];
				end
			end
			assign rise[gi] = sync2_q[gi] & ~prev_q[gi];
			assign fall[gi] = ~sync2_q[gi] & prev_q[gi];
		end
	endgenerate

	// ========================================================================
	// Instruction clock, source, prescaler and advance.
	// ========================================================================
	// The instruction clock is one cycle in four of the system clock.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			instr_div_q <= 2'h0;
		end else if (clk_en && !sleep_mode) begin
			instr_div_q <= instr_div_q + 2'h1;
		end
	end
	// No instruction clock exists while the device sleeps.
	assign instr_tick = (instr_div_q == ctp_pkg::INSTR_DIV_LAST) & ~sleep_mode;

	// Pick the edge of the chosen source; reserved codes never count.
	always_comb begin
		case (ctrl_b_q.clock_source_select)
			ctp_pkg::SRC_PIN:     src_edge = rise[0];
			ctp_pkg::SRC_PIN_INV: src_edge = fall[0]; // Rising edge of the inverted pin.
			ctp_pkg::SRC_INSTR:   src_edge = instr_tick;
			ctp_pkg::SRC_HF_OSC:  src_edge = rise[1];
			ctp_pkg::SRC_LF_OSC:  src_edge = rise[2];
			ctp_pkg::SRC_SEC_OSC: src_edge = rise[3];
			default:              src_edge = 1'b0;
		endcase
	end

	// Value n passes one edge in two to the n; zero passes every edge.
	assign prescale_mask = 15'((16'h1 << ctrl_b_q.prescale_ratio_select) - 16'h1);
	assign prescale_tick = src_edge & ((prescale_q & prescale_mask) == prescale_mask);
	// Low-byte and control writes restart the division.
	assign psc_clear     = wr_low | wr_ctrl;

	// The count has no read path and no write path from the bus.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prescale_q <= 15'h0000;
		end else if (clk_en) begin
			if (psc_clear || !ctrl_a_q.timer_run_enable) begin
				prescale_q <= 15'h0000;
			end else if (src_edge) begin
				prescale_q <= prescale_tick ? 15'h0000 : prescale_q + 15'h0001;
			end
		end
	end

	// Sync mode holds one edge for the next instruction slot; faster edges are lost.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pending_q <= 1'b0;
		end else if (clk_en) begin
			if (psc_clear || !ctrl_a_q.timer_run_enable || ctrl_b_q.async_input_enable) begin
				pending_q <= 1'b0;
			end else if (prescale_tick) begin
				pending_q <= 1'b1;
			end else if (instr_tick) begin
				pending_q <= 1'b0;
			end
		end
	end

	// Asynchronous mode uses the prescaler edge directly, sleep or not.
	always_comb begin
		if (!ctrl_a_q.timer_run_enable) begin
			advance = 1'b0;
		end else if (ctrl_b_q.async_input_enable) begin
			advance = prescale_tick;
		end else begin
			advance = pending_q & instr_tick;
		end
	end

	// A match in 8-bit mode or the wrap in 16-bit mode.
	assign wrap_event = advance & (ctrl_a_q.counter_width_select ? (count_q == ctp_pkg::COUNT_MAX)
		: (count_q[7:0] == period_shadow_q));
	assign timer_event = wrap_event;

	// ========================================================================
	// Counter, shadow period, postscaler and flag.
	// ========================================================================
	// A bus write to the low byte takes priority over a counting edge.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count_q <= {ctp_pkg::COUNT_RESET, ctp_pkg::COUNT_RESET};
		end else if (clk_en) begin
			if (wr_low) begin
				count_q <= {ctrl_a_q.counter_width_select ? count_high_q : count_q[15:8],
					w_byte_q};
			end else if (advance) begin
				if (ctrl_a_q.counter_width_select) begin
					count_q <= count_q + 16'h0001;
				end else if (wrap_event) begin
					count_q[7:0] <= 8'h00;
				end else begin
					count_q[7:0] <= count_q[7:0] + 8'h01;
				end
			end
		end
	end

	// The shadow period reloads from the high register at each match.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			period_shadow_q <= ctp_pkg::COUNT_RESET;
		end else if (clk_en && wrap_event && !ctrl_a_q.counter_width_select) begin
			period_shadow_q <= count_high_q;
		end
	end

	// High register: bus writes fill it; a 16-bit low read latches the upper byte.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count_high_q <= ctp_pkg::COUNT_RESET;
		end else if (clk_en) begin
			if (wr_high) begin
				count_high_q <= w_byte_q;
			end else if (rd_go && ar_idx == ctp_pkg::IDX_COUNT_LOW
					&& ctrl_a_q.counter_width_select) begin
				count_high_q <= count_q[15:8];
			end
		end
	end

	// Output toggles every postscale-plus-one events; 1:1 toggles on each.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			postscale_q            <= 4'h0;
			timer_output           <= 1'b0;
		end else if (clk_en) begin
			if (psc_clear) begin
				postscale_q <= 4'h0;
			end else if (wrap_event) begin
				if (postscale_q == ctrl_a_q.postscale_select) begin
					postscale_q  <= 4'h0;
					timer_output <= ~timer_output;
				end else begin
					postscale_q <= postscale_q + 4'h1;
				end
			end
		end
	end

	// Sticky flag; a postscaled event in the clearing cycle keeps it set.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else if (clk_en) begin
			if (wrap_event && postscale_q == ctrl_a_q.postscale_select) begin
				flag_q <= 1'b1;
			end else if (wr_stat && w_byte_q[ctp_pkg::STATUS_FLAG_BIT]) begin
				flag_q <= 1'b0;
			end
		end
	end

	// ========================================================================
	// Control registers.
	// ========================================================================
	// The output bit of control A mirrors the live output, never stored.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_a_q <= ctp_pkg::ctp_ctrl_a_t'(ctp_pkg::CTRL_A_RESET);
			ctrl_b_q <= ctp_pkg::ctp_ctrl_b_t'(ctp_pkg::CTRL_B_RESET);
		end else if (clk_en && wr_go && w_lane0_q) begin
			if (aw_idx_q == ctp_pkg::IDX_CTRL_A) begin
				ctrl_a_q <= ctp_pkg::ctp_ctrl_a_t'({w_byte_q[7], 2'b00, w_byte_q[4:0]});
			end else if (aw_idx_q == ctp_pkg::IDX_CTRL_B) begin
				ctrl_b_q <= ctp_pkg::ctp_ctrl_b_t'(w_byte_q);
			end
		end
	end

	// ========================================================================
	// AXI4-Lite slave.
	// ========================================================================
	// Address and data are taken in either order; the write happens once both are held.
	assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
	assign wr_go         = aw_have_q & w_have_q & ~s_axi_bvalid;
	assign wr_low        = wr_go & w_lane0_q & (aw_idx_q == ctp_pkg::IDX_COUNT_LOW);
	assign wr_high       = wr_go & w_lane0_q & (aw_idx_q == ctp_pkg::IDX_COUNT_HIGH);
	assign wr_stat       = wr_go & w_lane0_q & (aw_idx_q == ctp_pkg::IDX_STATUS);
	assign wr_ctrl       = wr_go & w_lane0_q & ((aw_idx_q == ctp_pkg::IDX_CTRL_A)
		| (aw_idx_q == ctp_pkg::IDX_CTRL_B));

	// Holding registers and the response.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			aw_idx_q     <= 12'h000;
			w_byte_q     <= 8'h00;
			w_lane0_q    <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ctp_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_idx_q  <= s_axi_awaddr[13:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q  <= 1'b1;
				w_byte_q  <= s_axi_wdata[7:0];
				w_lane0_q <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_idx_q >= ctp_pkg::IDX_COUNT_LOW && aw_idx_q <= ctp_pkg::IDX_STATUS)
					? ctp_pkg::RESP_OKAY : ctp_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// The read is answered at the same edge that takes the address.
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_go         = s_axi_arvalid & s_axi_arready;
	assign ar_idx        = s_axi_araddr[13:2];

	// Read data is registered; the prescaler never appears here.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= ctp_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= ctp_pkg::RESP_OKAY;
				s_axi_rdata  <= 32'h00000000; // Unmapped places read as zero.
				case (ar_idx)
					ctp_pkg::IDX_COUNT_LOW:  s_axi_rdata <= {24'h000000, count_q[7:0]};
					ctp_pkg::IDX_COUNT_HIGH: s_axi_rdata <= {24'h000000, count_high_q};
					ctp_pkg::IDX_CTRL_A:     s_axi_rdata <= {24'h000000, 8'(ctrl_a_q) | {2'b00, timer_output, 5'h00}};
					ctp_pkg::IDX_CTRL_B:     s_axi_rdata <= {24'h000000, ctrl_b_q};
					ctp_pkg::IDX_STATUS:     s_axi_rdata <= {31'h00000000, flag_q};
					default:                 s_axi_rresp <= ctp_pkg::RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : ctp_timer

// ===== tb/ctp_props.sv
// Checker for the timer's bus handshakes and event pulse.
// Assumes it is bound to ctp_timer and sees only its ports.
`timescale 1ns/1ps
module ctp_props (
	// Clock and reset.
	input wire logic        clk_sys,
	input wire logic        rst,
	// Bus ports.
	input wire logic [15:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Timer result.
	input wire logic        timer_event
);
	// ========================================================================
	// Address decode and properties.
	// ========================================================================
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Places outside the five registers must be refused.
	wire aw_bad = (s_axi_awaddr[13:2] < ctp_pkg::IDX_COUNT_LOW)
		|| (s_axi_awaddr[13:2] > ctp_pkg::IDX_STATUS);
	wire ar_bad = (s_axi_araddr[13:2] < ctp_pkg::IDX_COUNT_LOW)
		|| (s_axi_araddr[13:2] > ctp_pkg::IDX_STATUS);
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	r_unmap_a: assert property (s_axi_arvalid && s_axi_arready && ar_bad
		|=> s_axi_rresp == ctp_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	w_unmap_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && aw_bad |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == ctp_pkg::RESP_SLVERR))
		else $error("unmapped write not refused");
	ev_pulse_a: assert property (timer_event |=> !timer_event)
		else $error("event too long");
	cover property (s_axi_arvalid && s_axi_arready);
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (timer_event);
endmodule : ctp_props
bind ctp_timer ctp_props u_props (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_event(timer_event));

// ===== tb/ctp_src_model.sv
// Clock sources beside the timer: routed pin and three oscillators.
// Assumes the bench raises pin_run only while it wants pin edges.
`timescale 1ns/1ps
module ctp_src_model (
	// Control from the bench.
	input wire logic pin_run,
	// Clocks toward the timer.
	output logic     pin,
	output logic     hf,
	output logic     lf,
	output logic     sec
);
	// ========================================================================
	// Free-running oscillators, unrelated in phase to the system clock.
	// ========================================================================
	initial begin
		pin = 1'b0;
		hf = 1'b0;
		lf = 1'b0;
		sec = 1'b0;
	end
	always #11.5 hf = ~hf;
	always #30.5 lf = ~lf;
	always #48.5 sec = ~sec;
	// The pin rests low between bursts, as a pulled-down input would.
	always #18.5 pin = pin_run ? ~pin : 1'b0;
endmodule : ctp_src_model

// ===== tb/tb.sv
// Self-checking bench for the timer with prescaler.
// Assumes ctp_pkg, ctp_timer, ctp_props and ctp_src_model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb;
	// ========================================================================
	// Bench signals and scoreboard.
	// ========================================================================
	logic        clk_sys, rst, sleep_mode, pin_run, pin, hf, lf, sec, timer_output, timer_event;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [33:0] rq[$], mq[$], re, rm;
	logic [1:0]  bq[$], be;
	logic [7:0]  lo_seen, per;
	int          err_total = 0, cmp_count = 0, g;
	ctp_src_model u_src (.pin_run(pin_run), .pin(pin), .hf(hf), .lf(lf), .sec(sec));
	ctp_timer u_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .ext_clock_pin(pin),
		.high_freq_internal_osc(hf), .low_freq_internal_osc(lf), .secondary_oscillator(sec),
		.sleep_mode(sleep_mode), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.timer_output(timer_output), .timer_event(timer_event));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Bus write: address and data together, each released at its own taking edge.
	task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
		logic a, w, b;
		bq.push_back(er);
		awaddr <= {2'h0, idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk_sys);
			a = awready && awvalid;
			w = wready && wvalid;
			b = bvalid;
			@(posedge clk_sys);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end while (!b);
		bready <= 1'b0;
		@(posedge clk_sys);
	endtask : wr
	// Bus read: the expected answer and its mask go to the scoreboard first.
	task automatic rd(input logic [11:0] idx, input logic [33:0] e, input logic [33:0] m);
		logic r;
		rq.push_back(e);
		mq.push_back(m);
		araddr <= {2'h0, idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk_sys);
			r = arready;
			@(posedge clk_sys);
		end while (!r);
		arvalid <= 1'b0;
		do begin
			@(negedge clk_sys);
			r = rvalid;
			@(posedge clk_sys);
		end while (!r);
		rready <= 1'b0;
		@(posedge clk_sys);
	endtask : rd
	// Cycles from now to the next event pulse, less one.
	task automatic gap(output int n);
		n = 0;
		@(negedge clk_sys);
		while (timer_event !== 1'b1) begin
			n++;
			@(negedge clk_sys);
		end
	endtask : gap
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// Monitor: each answer is matched against the oldest note.
	always @(negedge clk_sys) begin
		if (rvalid && rready) begin
			re = rq.pop_front();
			rm = mq.pop_front();
			lo_seen = rdata[7:0];
			`CHK("read", re & rm, {rresp, rdata} & rm)
		end
		if (bvalid && bready) begin
			be = bq.pop_front();
			`CHK("bresp", be, bresp)
		end
	end
	// The span covers every scenario several times over.
	initial begin
		repeat (30000) @(posedge clk_sys);
		err_total++;
		report_and_stop();
	end
	// ========================================================================
	// Scenarios.
	// ========================================================================
	initial begin
		rst = 1'b1;
		{sleep_mode, pin_run, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
		{awaddr, araddr, wdata} = 64'h0;
		void'($urandom(32'h1A1B));
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		for (int i = 0; i < 5; i++) rd(ctp_pkg::IDX_COUNT_LOW + 12'(i), 34'h0, '1);
		rd(12'hFD7, {ctp_pkg::RESP_SLVERR, 32'h0}, '1);
		wr(12'hFD1, 8'hFF, ctp_pkg::RESP_SLVERR);
		// Stopped 16-bit load, then a high write that must only be buffered.
		wr(ctp_pkg::IDX_CTRL_A, 8'h10);
		wr(ctp_pkg::IDX_COUNT_HIGH, 8'h12);
		wr(ctp_pkg::IDX_COUNT_LOW, 8'h34);
		wr(ctp_pkg::IDX_COUNT_HIGH, 8'h56);
		repeat (20) @(posedge clk_sys);
		rd(ctp_pkg::IDX_COUNT_LOW, 34'h34, '1);
		rd(ctp_pkg::IDX_COUNT_HIGH, 34'h12, '1);
		// Wrap from the top of the 16-bit range.
		wr(ctp_pkg::IDX_COUNT_HIGH, 8'hFF);
		wr(ctp_pkg::IDX_COUNT_LOW, 8'hFE);
		wr(ctp_pkg::IDX_CTRL_B, {ctp_pkg::SRC_INSTR, 5'h0});
		wr(ctp_pkg::IDX_CTRL_A, 8'h90);
		gap(g);
		wr(ctp_pkg::IDX_CTRL_A, 8'h10);
		rd(ctp_pkg::IDX_COUNT_LOW, 34'h0, 34'h3FFFFFF00);
		rd(ctp_pkg::IDX_COUNT_HIGH, 34'h0, '1);
		rd(ctp_pkg::IDX_STATUS, 34'h1, '1);
		`CHK("output", 1'b1, timer_output)
		// 8-bit period against prescale ratios; steady interval is period+1 advances.
		for (int n = 0; n < 4; n++) begin
			per = 8'($urandom_range(1, 3));
			wr(ctp_pkg::IDX_CTRL_A, 8'h00);
			wr(ctp_pkg::IDX_COUNT_HIGH, per);
			wr(ctp_pkg::IDX_COUNT_LOW, 8'h00);
			wr(ctp_pkg::IDX_CTRL_B, {ctp_pkg::SRC_INSTR, 1'b0, 4'(n)});
			wr(ctp_pkg::IDX_CTRL_A, 8'h80);
			repeat (3) gap(g);
			`CHK("interval", (int'(per) + 1) * 4 * (1 << n), g + 1)
		end
		// Every source code, then sleep in synchronous and asynchronous mode.
		wr(ctp_pkg::IDX_COUNT_HIGH, 8'hFF);
		pin_run <= 1'b1;
		for (int s = 0; s < 10; s++) begin
			wr(ctp_pkg::IDX_CTRL_A, 8'h00);
			wr(ctp_pkg::IDX_COUNT_LOW, 8'h00);
			wr(ctp_pkg::IDX_CTRL_B, {(s < 8) ? 3'(s) : 3'(s - 6), s != 8, 4'h0});
			sleep_mode <= (s >= 8);
			wr(ctp_pkg::IDX_CTRL_A, 8'h80);
			repeat (300) @(posedge clk_sys);
			wr(ctp_pkg::IDX_CTRL_A, 8'h00);
			rd(ctp_pkg::IDX_COUNT_LOW, 34'h0, 34'h3FFFFFF00);
			`CHK("moved", (s < 6) || (s == 9), lo_seen != 8'h00)
		end
		report_and_stop();
	end
endmodule : tb
